// ---- rtl/coa_pkg.sv ----
// Package of constants for the compare output action control block.
`default_nettype none
package coa_pkg;
   // Widths and counts.
   localparam int DATA_W = 16;
   localparam int ADDR_W = 16;
   localparam int FULL_UNITS = 3;
   localparam int FULL_PINS = 6;
   localparam int SIMPLE_PINS = 3;
   localparam int FLAGS = 6;
   localparam int DB_TMR_W = 8;
   localparam int PSC_W = 3;
   localparam int ACT_W = 2;
   localparam int VEC_W = 3;

   // Register word addresses.
   localparam logic [15:0] COMPARE_CTRL_ADDR = 16'h7411;
   localparam logic [15:0] FULL_ACTION_ADDR = 16'h7413;
   localparam logic [15:0] SIMPLE_ACTION_ADDR = 16'h7414;
   localparam logic [15:0] DEAD_BAND_ADDR = 16'h7415;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // Compare control fields.
   localparam int CC_ON_BIT = 15;
   localparam int CC_SV_BIT = 12;
   localparam int CC_FULL_RLD_LSB = 10;
   localparam int CC_FULL_OE_BIT = 9;
   localparam int CC_SIMPLE_OE_BIT = 8;
   localparam int CC_TMR_SEL_BIT = 7;
   localparam int CC_SIMPLE_RLD_LSB = 3;
   localparam int CC_MODE_LSB = 0;

   // Full action fields; output n sits at bits 2n-1..2n-2.
   localparam int FA_DIR_BIT = 15;
   localparam int FA_VEC_LSB = 12;
   localparam int FA_ACT_LSB = 0;

   // Simple action and dead-band writable bits.
   localparam logic [15:0] SA_WRITE_MASK = 16'h003f;
   localparam logic [15:0] DB_WRITE_MASK = 16'hfff8;
   localparam int DB_PERIOD_LSB = 8;
   localparam int DB_EN_LSB = 5;
   localparam int DB_PSC_LSB = 3;

   // Reload selector codes; the fourth code is reserved.
   localparam logic [1:0] RLD_ZERO = 2'h0;
   localparam logic [1:0] RLD_ZERO_PRD = 2'h1;
   localparam logic [1:0] RLD_NOW = 2'h2;

   // Action codes: compare-mode meaning / PWM-mode meaning.
   localparam logic [1:0] ACT_HOLD_FLOW = 2'h0;
   localparam logic [1:0] ACT_RESET_ALOW = 2'h1;
   localparam logic [1:0] ACT_SET_AHIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE_FHIGH = 2'h3;
endpackage : coa_pkg
`default_nettype wire

// ---- rtl/coa_db_if.sv ----
// Interface between the output control and the dead-band unit.
`timescale 1ns/1ps
`default_nettype none
interface coa_db_if;
   import coa_pkg::*;
   logic [FULL_UNITS-1:0] ph;
   logic [FULL_UNITS-1:0] en;
   logic [DB_TMR_W-1:0] period;
   logic [1:0] psc_sel;
   logic [FULL_UNITS-1:0] dt_hi;
   logic [FULL_UNITS-1:0] dt_lo;
   modport unit (input ph, input en, input period, input psc_sel, output dt_hi, output dt_lo);
   modport ctrl (output ph, output en, output period, output psc_sel, input dt_hi, input dt_lo);
endinterface : coa_db_if
`default_nettype wire

// ---- rtl/coa_dead_band.sv ----
// Dead-band unit: three prescaled 8-bit down-counting gap timers.
`timescale 1ns/1ps
`default_nettype none
module coa_dead_band
   import coa_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_q_n,
   coa_db_if.unit dbi
);
   // Last prescaler count: the timer steps every 1, 2, 4 or 8 clocks.
   wire [PSC_W-1:0] psc_last = PSC_W'((4'h1 << dbi.psc_sel) - 4'h1);

   genvar i;
   for (i = 0; i < FULL_UNITS; i++)
   begin : g_unit
      logic ph_d_reg;
      logic [DB_TMR_W-1:0] cnt_reg;
      logic [DB_TMR_W-1:0] cnt_next;
      logic [PSC_W-1:0] psc_reg;
      logic [PSC_W-1:0] psc_next;

      // An edge reloads the timer and counts as the first gap clock, so the
      // gap is exactly period times prescale clocks.
      wire load_w = (dbi.ph[i] ^ ph_d_reg) && dbi.en[i];
      wire [DB_TMR_W-1:0] cnt_eff = load_w ? dbi.period : cnt_reg;
      wire [PSC_W-1:0] psc_eff = load_w ? '0 : psc_reg;
      wire wrap_w = psc_eff == psc_last;
      wire busy_w = cnt_eff != '0;
      assign cnt_next = (busy_w && wrap_w) ? cnt_eff - DB_TMR_W'(1) : cnt_eff;
      assign psc_next = (!busy_w || wrap_w) ? '0 : psc_eff + PSC_W'(1);

      // Both sides stay low during the gap; disabled units pass the phase.
      assign dbi.dt_hi[i] = dbi.en[i] ? (dbi.ph[i] && !busy_w) : dbi.ph[i];
      assign dbi.dt_lo[i] = dbi.en[i] ? (!dbi.ph[i] && !busy_w) : !dbi.ph[i];

      // Timer state.
      always_ff @(posedge sys_clk or negedge rst_q_n)
      begin
         if (!rst_q_n)
         begin
            ph_d_reg <= 1'b0;
            cnt_reg <= '0;
            psc_reg <= '0;
         end
         else
         begin
            ph_d_reg <= dbi.ph[i];
            cnt_reg <= cnt_next;
            psc_reg <= psc_next;
         end
      end

      db_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
         ($rose(dbi.ph[i]) && dbi.en[i] && dbi.period != '0) |-> !dbi.dt_hi[i] && !dbi.dt_lo[i])
         else $error("Dead band output rose with no gap.");
   end
endmodule : coa_dead_band
`default_nettype wire

// ---- rtl/coa_top.sv ----
// Compare output action control: action registers, output pins and flags.
`timescale 1ns/1ps
`default_nettype none
module coa_top
   import coa_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [DATA_W-1:0] bus_wdata,
   output logic [DATA_W-1:0] bus_rdata,
   input wire logic t1_zero,
   input wire logic t1_period,
   input wire logic t2_zero,
   input wire logic t2_period,
   input wire logic [FULL_UNITS-1:0] full_match,
   input wire logic [FULL_UNITS-1:0] full_wave,
   input wire logic [SIMPLE_PINS-1:0] simple_match,
   input wire logic [SIMPLE_PINS-1:0] simple_wave,
   input wire logic [FLAGS-1:0] irq_mask,
   input wire logic [FLAGS-1:0] flag_clr,
   output logic [FLAGS-1:0] cmp_flag,
   output logic [FLAGS-1:0] irq_req,
   output logic sv_rotation_dir,
   output logic [VEC_W-1:0] sv_basic_vector,
   output logic [FULL_PINS+SIMPLE_PINS-1:0] pin_out,
   output logic [FULL_PINS+SIMPLE_PINS-1:0] pin_oe
);
   localparam int PINS = FULL_PINS + SIMPLE_PINS;

   // PWM polarity: forced low, active low, active high, forced high.
   function automatic logic polarity(input logic [1:0] act, input logic wave);
      logic res;
      res = 1'b0;
      unique case (act)
         ACT_HOLD_FLOW: res = 1'b0;
         ACT_RESET_ALOW: res = !wave;
         ACT_SET_AHIGH: res = wave;
         ACT_TOGGLE_FHIGH: res = 1'b1;
      endcase
      return res;
   endfunction : polarity

   // Compare-mode action on a match: hold, reset, set or toggle.
   function automatic logic cmp_action(input logic [1:0] act, input logic cur);
      logic res;
      res = cur;
      unique case (act)
         ACT_HOLD_FLOW: res = cur;
         ACT_RESET_ALOW: res = 1'b0;
         ACT_SET_AHIGH: res = 1'b1;
         ACT_TOGGLE_FHIGH: res = !cur;
      endcase
      return res;
   endfunction : cmp_action

   // Reload decision; the reserved code never reloads.
   function automatic logic reload_due(input logic [1:0] sel, input logic zero, input logic prd);
      return (sel == RLD_NOW) || (sel == RLD_ZERO && zero) || (sel == RLD_ZERO_PRD && (zero || prd));
   endfunction : reload_due

   logic rst_s1_reg;
   logic rst_q_n;
   logic [DATA_W-1:0] cc_reg;
   logic [DATA_W-1:0] fa_shadow_reg;
   logic [DATA_W-1:0] fa_active_reg;
   logic [DATA_W-1:0] sa_shadow_reg;
   logic [DATA_W-1:0] sa_active_reg;
   logic [DATA_W-1:0] db_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [PINS-1:0] pin_reg;
   logic [PINS-1:0] pin_next;
   logic [FLAGS-1:0] match_d_reg;
   logic [FLAGS-1:0] flag_reg;
   logic [FLAGS-1:0] flag_next;

   // Reset is asserted at once and released through two flip-flops.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_reg <= 1'b0;
         rst_q_n <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_q_n <= rst_s1_reg;
      end
   end

   // Address decode and control fields.
   wire cc_sel_w = bus_addr == COMPARE_CTRL_ADDR;
   wire fa_sel_w = bus_addr == FULL_ACTION_ADDR;
   wire sa_sel_w = bus_addr == SIMPLE_ACTION_ADDR;
   wire db_sel_w = bus_addr == DEAD_BAND_ADDR;
   wire fa_wr_w = bus_wr && fa_sel_w;
   wire sa_wr_w = bus_wr && sa_sel_w;
   wire compare_on = cc_reg[CC_ON_BIT];
   wire [1:0] full_action_reload_sel = cc_reg[CC_FULL_RLD_LSB +: 2];
   wire [1:0] simple_action_reload_sel = cc_reg[CC_SIMPLE_RLD_LSB +: 2];
   wire simple_tmr_sel = cc_reg[CC_TMR_SEL_BIT];
   wire [FULL_UNITS-1:0] pwm_mode_w = {FULL_UNITS{cc_reg[CC_SV_BIT]}} | cc_reg[CC_MODE_LSB +: FULL_UNITS];

   // Shadow sources: a write this cycle is seen by a reload in the same cycle.
   wire [DATA_W-1:0] fa_src_w = fa_wr_w ? bus_wdata : fa_shadow_reg;
   wire [DATA_W-1:0] sa_src_w = sa_wr_w ? (bus_wdata & SA_WRITE_MASK) : sa_shadow_reg;
   wire st_zero_w = simple_tmr_sel ? t2_zero : t1_zero;
   wire st_prd_w = simple_tmr_sel ? t2_period : t1_period;

   // With compare off the active copy follows the shadow every cycle.
   wire fa_rld_w = !compare_on || reload_due(full_action_reload_sel, t1_zero, t1_period);
   wire sa_rld_w = !compare_on || reload_due(simple_action_reload_sel, st_zero_w, st_prd_w);

   // Register file; every reset clears all of it.
   always_ff @(posedge sys_clk or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         cc_reg <= REG_RESET;
         fa_shadow_reg <= REG_RESET;
         fa_active_reg <= REG_RESET;
         sa_shadow_reg <= REG_RESET;
         sa_active_reg <= REG_RESET;
         db_reg <= REG_RESET;
      end
      else
      begin
         if (bus_wr && cc_sel_w)
            cc_reg <= bus_wdata;
         if (bus_wr && db_sel_w)
            db_reg <= bus_wdata & DB_WRITE_MASK;
         fa_shadow_reg <= fa_src_w;
         sa_shadow_reg <= sa_src_w;
         if (fa_rld_w)
            fa_active_reg <= fa_src_w;
         if (sa_rld_w)
            sa_active_reg <= sa_src_w;
      end
   end

   // Read path: reads return the shadow copies, unmapped words read zero.
   wire [DATA_W-1:0] rd_mux_w = cc_sel_w ? cc_reg :
                                fa_sel_w ? fa_shadow_reg :
                                sa_sel_w ? sa_shadow_reg :
                                db_sel_w ? db_reg : '0;

   always_ff @(posedge sys_clk or negedge rst_q_n)
   begin
      if (!rst_q_n)
         rdata_reg <= '0;
      else
         rdata_reg <= bus_rd ? rd_mux_w : '0;
   end

   // Dead-band timers only run for units in PWM mode.
   coa_db_if dbi ();
   assign dbi.ph = full_wave;
   assign dbi.en = db_reg[DB_EN_LSB +: FULL_UNITS] & pwm_mode_w;
   assign dbi.period = db_reg[DB_PERIOD_LSB +: DB_TMR_W];
   assign dbi.psc_sel = db_reg[DB_PSC_LSB +: 2];

   coa_dead_band u_dead_band (
      .sys_clk(sys_clk),
      .rst_q_n(rst_q_n),
      .dbi(dbi.unit)
   );

   // Full pins: even index takes the upper phase, odd index the lower one.
   // Pin n uses bits 2n-1..2n-2 of the active copy.
   genvar j;
   for (j = 0; j < FULL_PINS; j++)
   begin : g_full
      localparam int U = j / 2;
      wire [1:0] act_w = fa_active_reg[FA_ACT_LSB + ACT_W*j +: ACT_W];
      wire dt_w = (j % 2 == 0) ? dbi.dt_hi[U] : dbi.dt_lo[U];
      wire pwm_w = polarity(act_w, dt_w);
      wire cmp_w = full_match[U] ? cmp_action(act_w, pin_reg[j]) : pin_reg[j];
      assign pin_next[j] = !compare_on ? pin_reg[j] : (pwm_mode_w[U] ? pwm_w : cmp_w);
   end

   // Simple pins only have the polarity encoding.
   genvar k;
   for (k = 0; k < SIMPLE_PINS; k++)
   begin : g_simple
      wire [1:0] act_w = sa_active_reg[ACT_W*k +: ACT_W];
      assign pin_next[FULL_PINS+k] = compare_on ? polarity(act_w, simple_wave[k]) : pin_reg[FULL_PINS+k];
   end

   // Pins are sampled every clock, so widths step in single clocks.
   always_ff @(posedge sys_clk or negedge rst_q_n)
   begin
      if (!rst_q_n)
         pin_reg <= '0;
      else
         pin_reg <= pin_next;
   end

   // Match is delayed one stage and the flag lands one stage later.
   // A set in the clearing cycle wins so no event is lost.
   assign flag_next = (flag_reg & ~flag_clr) | match_d_reg;

   always_ff @(posedge sys_clk or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         match_d_reg <= '0;
         flag_reg <= '0;
      end
      else
      begin
         match_d_reg <= {simple_match, full_match} & {FLAGS{compare_on}};
         flag_reg <= flag_next;
      end
   end

   // Requests per group; the lower index has the higher priority.
   wire [FLAGS-1:0] pend_w = flag_reg & irq_mask;
   genvar f;
   for (f = 0; f < FLAGS; f++)
   begin : g_irq
      localparam int BASE = (f < FULL_UNITS) ? 0 : FULL_UNITS;
      localparam logic [FLAGS-1:0] HIGHER = FLAGS'((1 << f) - (1 << BASE));
      assign irq_req[f] = pend_w[f] && ((pend_w & HIGHER) == '0);
   end

   // Outputs; enables are clear from reset, which keeps the pins floating.
   assign pin_oe = {{SIMPLE_PINS{cc_reg[CC_SIMPLE_OE_BIT]}}, {FULL_PINS{cc_reg[CC_FULL_OE_BIT]}}};
   assign pin_out = pin_reg;
   assign bus_rdata = rdata_reg;
   assign cmp_flag = flag_reg;
   assign sv_rotation_dir = fa_active_reg[FA_DIR_BIT];
   assign sv_basic_vector = fa_active_reg[FA_VEC_LSB +: VEC_W];

   transp_write_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (fa_wr_w && !compare_on) |=> fa_active_reg == $past(bus_wdata))
      else $error("Write with compare off did not reach the active copy.");

   reload_now_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (compare_on && full_action_reload_sel == RLD_NOW && !fa_wr_w) |=> fa_active_reg == $past(fa_shadow_reg))
      else $error("Immediate reload did not copy the shadow.");

   reload_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (compare_on && full_action_reload_sel == RLD_ZERO && !t1_zero) |=> $stable(fa_active_reg))
      else $error("Active action changed without a reload event.");

   simple_timer_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (compare_on && simple_action_reload_sel == RLD_ZERO && simple_tmr_sel && t2_zero && !sa_wr_w)
      |=> sa_active_reg == $past(sa_shadow_reg))
      else $error("Simple reload ignored the selected timer.");

   simple_rsvd_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      ((sa_shadow_reg | sa_active_reg) & ~SA_WRITE_MASK) == '0)
      else $error("Reserved simple action bits are not zero.");

   flag_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (full_match[0] && compare_on) |-> ##2 cmp_flag[0])
      else $error("Compare flag not set two cycles after match.");

   irq_prio_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      irq_req[1] |-> irq_mask[1] && cmp_flag[1] && !(cmp_flag[0] && irq_mask[0]))
      else $error("Request raised past a higher pending flag.");

   pin_hiz_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      $rose(rst_q_n) |-> pin_oe == '0)
      else $error("Pins driven right after reset.");

   pwm_forced_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (compare_on && pwm_mode_w[2] && fa_active_reg[ACT_W*4 +: ACT_W] == ACT_TOGGLE_FHIGH) |=> pin_out[4])
      else $error("Forced high PWM pin is low.");

   cmp_toggle_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (compare_on && !pwm_mode_w[2] && full_match[2] && fa_active_reg[ACT_W*5 +: ACT_W] == ACT_TOGGLE_FHIGH)
      |=> pin_out[5] != $past(pin_out[5]))
      else $error("Toggle on match did not toggle.");

   enable_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      !compare_on |=> $stable(pin_out))
      else $error("Pin moved with compare disabled.");

   flag_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (match_d_reg != '0) |=> (cmp_flag & $past(match_d_reg)) == $past(match_d_reg))
      else $error("Compare flag lost to a clear in the same cycle.");

   simple_forced_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (compare_on && sa_active_reg[ACT_W*2 +: ACT_W] == ACT_TOGGLE_FHIGH) |=> pin_out[FULL_PINS+2])
      else $error("Forced high simple pin is low.");

   pass_through_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (compare_on && pwm_mode_w[0] && !dbi.en[0] && fa_active_reg[FA_ACT_LSB +: ACT_W] == ACT_SET_AHIGH)
      |=> pin_out[0] == $past(full_wave[0]))
      else $error("Active high pin does not follow its wave.");

   reserved_code_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (compare_on && (&full_action_reload_sel)) |=> $stable(fa_active_reg))
      else $error("Reserved reload code changed the active copy.");

   simple_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_q_n)
      (compare_on && simple_action_reload_sel == RLD_ZERO && !st_zero_w) |=> $stable(sa_active_reg))
      else $error("Simple active copy changed without a reload event.");
endmodule : coa_top
`default_nettype wire

// ---- bench/coa_gate_drv.sv ----
// Behavioural model of the inverter gate-driver inputs fed by the compare pins.
`timescale 1ns/1ps
`default_nettype none
module coa_gate_drv
   import coa_pkg::*;
(
   input wire logic [FULL_PINS+SIMPLE_PINS-1:0] pin_out,
   input wire logic [FULL_PINS+SIMPLE_PINS-1:0] pin_oe,
   output logic [FULL_PINS+SIMPLE_PINS-1:0] gate_on
);
   // Each driver input has a pull-down, so a released pin keeps its switch off rather than floating.
   tri0 [FULL_PINS+SIMPLE_PINS-1:0] pin_wire;
   genvar i;
   for (i = 0; i < FULL_PINS + SIMPLE_PINS; i++)
   begin : g_pin
      assign pin_wire[i] = pin_oe[i] ? pin_out[i] : 1'bz;
   end
   // The switch follows the resolved wire level, never the undriven register value.
   assign gate_on = pin_wire;
endmodule : coa_gate_drv
`default_nettype wire

// ---- bench/compare_output_action_control_test.sv ----
// Self-checking testbench for the compare output action control block.
`timescale 1ns/1ps
`default_nettype none
module compare_output_action_control_test;
   import coa_pkg::*;
   localparam int LIMIT = 4000;
   localparam logic [15:0] CMP_ACT [4] = '{16'h0aaa, 16'h0000, 16'h0fff, 16'h00c6};
   localparam logic [15:0] CMP_PIN [4] = '{16'h003f, 16'h003f, 16'h0000, 16'h0009};
   localparam logic [15:0] PWM_ACT [4] = '{16'h0aaa, 16'h0555, 16'h0fff, 16'h0000};
   localparam logic [15:0] PWM_PIN [4] = '{16'h0019, 16'h0026, 16'h003f, 16'h0000};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] bus_addr = 16'h0000;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [15:0] bus_wdata = 16'h0000;
   logic [15:0] bus_rdata;
   logic [3:0] tmr_ev = 4'h0;
   logic [2:0] full_match = 3'h0;
   logic [2:0] full_wave = 3'h0;
   logic [2:0] simple_match = 3'h0;
   logic [2:0] simple_wave = 3'h0;
   logic [5:0] irq_mask = 6'h37;
   logic [5:0] flag_clr = 6'h00;
   logic [5:0] cmp_flag;
   logic [5:0] irq_req;
   logic sv_rotation_dir;
   logic [2:0] sv_basic_vector;
   logic [8:0] pin_out;
   logic [8:0] pin_oe;
   logic [8:0] gate_on;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;

   coa_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .t1_zero(tmr_ev[0]), .t1_period(tmr_ev[1]),
      .t2_zero(tmr_ev[2]), .t2_period(tmr_ev[3]), .full_match(full_match), .full_wave(full_wave),
      .simple_match(simple_match), .simple_wave(simple_wave), .irq_mask(irq_mask), .flag_clr(flag_clr),
      .cmp_flag(cmp_flag), .irq_req(irq_req), .sv_rotation_dir(sv_rotation_dir),
      .sv_basic_vector(sv_basic_vector), .pin_out(pin_out), .pin_oe(pin_oe));
   coa_gate_drv u_drv (.pin_out(pin_out), .pin_oe(pin_oe), .gate_on(gate_on));

   // The clock toggles every 20 ns, half of its 40 ns period.
   always #20 sys_clk = ~sys_clk;

   // A hang is cut short so that the verdict is always printed.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         failures++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks=%0d mismatches=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Waits n edges, then lets that edge's updates settle before sampling.
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask : wr

   // Read data is registered, so it is sampled just after the edge that took the strobe.
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      chk(bus_rdata, exp);
   endtask : rd_chk

   // One-cycle pulse on timer events, match strobes and flag clears together.
   task automatic pulse_ev(input logic [3:0] t, input logic [2:0] fm, input logic [2:0] sm, input logic [5:0] c);
      @(posedge sys_clk);
      tmr_ev <= t;
      full_match <= fm;
      simple_match <= sm;
      flag_clr <= c;
      @(posedge sys_clk);
      tmr_ev <= 4'h0;
      full_match <= 3'h0;
      simple_match <= 3'h0;
      flag_clr <= 6'h00;
   endtask : pulse_ev

   task automatic t_reset();
      rd_chk(FULL_ACTION_ADDR, 16'h0000);
      rd_chk(SIMPLE_ACTION_ADDR, 16'h0000);
      rd_chk(COMPARE_CTRL_ADDR, 16'h0000);
      chk(16'(pin_oe), 16'h0000);
      chk(16'(gate_on), 16'h0000);
   endtask : t_reset

   task automatic t_regs();
      wr(SIMPLE_ACTION_ADDR, 16'hffff);
      rd_chk(SIMPLE_ACTION_ADDR, 16'h003f);
      wr(16'h7412, 16'hffff);
      rd_chk(16'h7412, 16'h0000);
      wr(FULL_ACTION_ADDR, 16'hf000);
      rd_chk(FULL_ACTION_ADDR, 16'hf000);
      tick(1);
      chk(16'(sv_rotation_dir), 16'h0001);
      chk(16'(sv_basic_vector), 16'h0007);
   endtask : t_regs

   task automatic t_compare();
      wr(COMPARE_CTRL_ADDR, 16'h0b10);
      wr(FULL_ACTION_ADDR, 16'h0aaa);
      pulse_ev(4'h0, 3'h7, 3'h0, 6'h00);
      tick(3);
      chk(16'(pin_out[5:0]), 16'h0000);
      chk(16'(cmp_flag), 16'h0000);
      wr(COMPARE_CTRL_ADDR, 16'h8b10);
      tick(2);
      chk(16'(pin_oe), 16'h01ff);
      for (int k = 0; k < 4; k++)
      begin
         wr(FULL_ACTION_ADDR, CMP_ACT[k]);
         pulse_ev(4'h0, 3'h7, 3'h0, 6'h00);
         tick(2);
         chk(16'(pin_out[5:0]), CMP_PIN[k]);
         chk(16'(gate_on[5:0]), CMP_PIN[k]);
      end
   endtask : t_compare

   task automatic t_flags();
      pulse_ev(4'h0, 3'h0, 3'h0, 6'h3f);
      tick(1);
      chk(16'(cmp_flag), 16'h0000);
      // The match was taken at the last edge; the flag lands one edge later.
      pulse_ev(4'h0, 3'h2, 3'h0, 6'h00);
      tick(0);
      chk(16'(cmp_flag), 16'h0000);
      tick(1);
      chk(16'(cmp_flag), 16'h0002);
      chk(16'(irq_req), 16'h0002);
      pulse_ev(4'h0, 3'h1, 3'h1, 6'h00);
      tick(2);
      chk(16'(cmp_flag), 16'h000b);
      chk(16'(irq_req), 16'h0001);
      pulse_ev(4'h0, 3'h0, 3'h0, 6'h01);
      tick(1);
      chk(16'(irq_req), 16'h0002);
   endtask : t_flags

   task automatic t_pwm();
      wr(COMPARE_CTRL_ADDR, 16'h0b17);
      wr(COMPARE_CTRL_ADDR, 16'h8b17);
      full_wave <= 3'h5;
      simple_wave <= 3'h3;
      for (int k = 0; k < 4; k++)
      begin
         wr(FULL_ACTION_ADDR, PWM_ACT[k]);
         tick(4);
         chk(16'(pin_out[5:0]), PWM_PIN[k]);
      end
      wr(SIMPLE_ACTION_ADDR, 16'h0036);
      tick(4);
      chk(16'(pin_out[8:6]), 16'h0005);
      wr(SIMPLE_ACTION_ADDR, 16'h0009);
      tick(4);
      chk(16'(pin_out[8:6]), 16'h0002);
   endtask : t_pwm

   task automatic t_reload();
      wr(COMPARE_CTRL_ADDR, 16'h8387);
      wr(FULL_ACTION_ADDR, 16'h5000);
      wr(SIMPLE_ACTION_ADDR, 16'h003f);
      tick(2);
      chk(16'(sv_basic_vector), 16'h0000);
      chk(16'(pin_out[8:6]), 16'h0002);
      pulse_ev(4'h2, 3'h0, 3'h0, 6'h00);
      tick(2);
      chk(16'(sv_basic_vector), 16'h0000);
      pulse_ev(4'h1, 3'h0, 3'h0, 6'h00);
      tick(2);
      chk(16'(sv_basic_vector), 16'h0005);
      chk(16'(pin_out[8:6]), 16'h0002);
      pulse_ev(4'h4, 3'h0, 3'h0, 6'h00);
      tick(3);
      chk(16'(pin_out[8:6]), 16'h0007);
      wr(COMPARE_CTRL_ADDR, 16'h878f);
      wr(FULL_ACTION_ADDR, 16'ha000);
      wr(SIMPLE_ACTION_ADDR, 16'h0000);
      pulse_ev(4'ha, 3'h0, 3'h0, 6'h00);
      tick(3);
      chk(16'(sv_rotation_dir), 16'h0001);
      chk(16'(sv_basic_vector), 16'h0002);
      chk(16'(pin_out[8:6]), 16'h0000);
      wr(COMPARE_CTRL_ADDR, 16'h8f87);
      wr(FULL_ACTION_ADDR, 16'h0000);
      pulse_ev(4'h3, 3'h0, 3'h0, 6'h00);
      tick(2);
      chk(16'(sv_basic_vector), 16'h0002);
   endtask : t_reload

   // Dead band with period 3 and prescale 2 under space-vector mode: a six clock gap on unit 0.
   task automatic t_deadband();
      wr(COMPARE_CTRL_ADDR, 16'h1b00);
      wr(DEAD_BAND_ADDR, 16'h03ef);
      rd_chk(DEAD_BAND_ADDR, 16'h03e8);
      wr(FULL_ACTION_ADDR, 16'h0aaa);
      wr(COMPARE_CTRL_ADDR, 16'h9b00);
      full_wave <= 3'h4;
      tick(6);
      chk(16'(pin_out[5:0]), 16'h0018);
      tick(1);
      chk(16'(pin_out[5:0]), 16'h001a);
      @(posedge sys_clk);
      full_wave <= 3'h5;
      tick(7);
      chk(16'(pin_out[5:0]), 16'h0019);
   endtask : t_deadband

   task automatic t_midreset();
      @(posedge sys_clk);
      rst_n <= 1'b0;
      tick(1);
      chk(16'(pin_oe), 16'h0000);
      chk(16'(gate_on), 16'h0000);
      chk(16'(cmp_flag), 16'h0000);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      tick(3);
      rd_chk(FULL_ACTION_ADDR, 16'h0000);
      rd_chk(COMPARE_CTRL_ADDR, 16'h0000);
   endtask : t_midreset

   // Main sequence: hold reset for two cycles, wait out the internal release, then run each scenario.
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      tick(3);
      t_reset();
      t_regs();
      t_compare();
      t_flags();
      t_pwm();
      t_reload();
      t_deadband();
      t_midreset();
      test_done();
   end
endmodule : compare_output_action_control_test
`default_nettype wire
